// [src/ecpx_defs.vh]
// ecpx_defs.vh: register offsets, field positions, reset values and sizes for the
// extended register set of the parallel port.
// assumes: included by bare name from the design file; APB byte addresses.
// Notes on behaviour
// - test mode pushes/pops without peripheral cycles
// - test mode forward keeps data lines driven
// - full writes, empty reads ignored; FIFO order
// - config A read-only, fixed 0001x100 pattern
// - config A bit3 mirrors config bit7
// - config B bits1-0 mirror DMA channel
// - config B bits5-3 mirror IRQ number
// - config B bit6 live IRQ; 2,7 zero
// - extended control resets to 00010xx1
// - stall read until status bits updated
// - bit0 empty, or 1 when clock frozen
// - bit1 full, or 1 when clock frozen
// - service bit set by reset/events, software clears
// - frozen clock reads service bit as zero
// - events: terminal count or FIFO thresholds
// - DMA enable gates request, acknowledge ignored otherwise
// - fault falling edge or unmask interrupts
// - bits 7-5 select port mode
// - index selects four second-level registers
// - index bits 7-3 read zero, ignored
// - second level gated by global enable
// - second-level defaults only on reset
// - direction 0 drives lines, 1 releases
`ifndef ECPX_DEFS_VH
`define ECPX_DEFS_VH
`define ECPX_ADDR_FIFO      12'h000
`define ECPX_ADDR_CFGA      12'h004
`define ECPX_ADDR_CFGB      12'h008
`define ECPX_ADDR_ECTL      12'h00c
`define ECPX_ADDR_INDEX     12'h010
`define ECPX_ADDR_DATA      12'h014
`define ECPX_ADDR_PCTL      12'h018
`define ECPX_MODE_STD       3'h0
`define ECPX_MODE_BYTE      3'h1
`define ECPX_MODE_PPFIFO    3'h2
`define ECPX_MODE_ECPFIFO   3'h3
`define ECPX_MODE_EPP       3'h4
`define ECPX_MODE_TEST      3'h6
`define ECPX_MODE_CONFIG    3'h7
`define ECPX_SL_CTRL0       3'h0
`define ECPX_SL_CTRL2       3'h2
`define ECPX_SL_CTRL4       3'h4
`define ECPX_SL_PPCFG       3'h5
`define ECPX_ECTL_RESET     8'h15
`define ECPX_CTRL4_RESET    8'h07
`define ECPX_CFGA_FIXED     8'h14
`define ECPX_PCTL_RESET     8'h00
`define ECPX_FIFO_DEPTH     16
`define ECPX_FIFO_AW        4
`define ECPX_THRESH         5'h08
`define ECPX_BIT_EMPTY      0
`define ECPX_BIT_FULL       1
`define ECPX_BIT_SERV       2
`define ECPX_BIT_DMAEN      3
`define ECPX_BIT_FMASK      4
`define ECPX_BIT_DIR        5
`define ECPX_BIT_CFGA7      7
`endif

// [src/ecpx_ext_regs.v]
// ecpx_ext_regs.v: extended register set of the parallel port: test FIFO,
// two configuration readback registers, extended control, second-level index/data.
// assumes: APB master on the same clock; fault, irq level, terminal count and
// frozen indication are synchronous inputs; data lines are resolved by the bench.
`include "ecpx_defs.vh"
module ecpx_ext_regs (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        clk_frozen,
  input  wire        fault_n,
  input  wire        irq_level,
  input  wire        dma_tc,
  input  wire        sl_enable,
  input  wire [7:0]  pd_in,
  output wire [7:0]  pd_out,
  output wire        pd_oe_n,
  output wire        dma_req,
  output wire        dma_req_oe_n,
  output wire        irq_out
);
  reg  [7:0]  fifo_mem_reg [0:`ECPX_FIFO_DEPTH-1];
  reg  [3:0]  rd_ptr_reg;
  reg  [3:0]  wr_ptr_reg;
  reg  [4:0]  count_reg;
  reg  [7:0]  ectl_reg;
  reg  [2:0]  index_reg;
  reg  [7:0]  ctrl0_reg;
  reg  [7:0]  ctrl2_reg;
  reg  [7:0]  ctrl4_reg;
  reg  [7:0]  ppcfg_reg;
  reg  [7:0]  pctl_reg;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg         stat_valid_reg;
  reg         fault_d_reg;
  reg         irq_reg;
  reg  [7:0]  pd_out_reg;
  reg         pd_oe_n_reg;
  reg         dma_req_reg;
  reg         dma_req_oe_n_reg;
  reg  [7:0]  rdata_next;
  reg         hit;
  wire [2:0]  mode = ectl_reg[7:5];
  wire        dir  = pctl_reg[`ECPX_BIT_DIR];
  wire        fifo_empty = (count_reg == 5'h00);
  wire        fifo_full  = (count_reg == `ECPX_FIFO_DEPTH);
  wire        setup  = psel & ~penable;
  wire        access = psel & penable & pready_reg;
  wire        wr_acc = access & pwrite;
  wire        rd_acc = access & ~pwrite;
  wire [7:0]  wbyte  = pwdata[7:0];
  integer     i;

  // second-level register is reachable only at a supported offset with the global enable
  function sl_valid;
    input [2:0] idx;
    input       en;
    begin
      sl_valid = en & ((idx == `ECPX_SL_CTRL0) | (idx == `ECPX_SL_CTRL2) |
                       (idx == `ECPX_SL_CTRL4) | (idx == `ECPX_SL_PPCFG));
    end
  endfunction

  wire in_test  = (mode == `ECPX_MODE_TEST);
  wire push = wr_acc & in_test & (paddr == `ECPX_ADDR_FIFO) & ~fifo_full;
  wire pop  = rd_acc & in_test & (paddr == `ECPX_ADDR_FIFO) & ~fifo_empty;
  wire in_cfg = (mode == `ECPX_MODE_CONFIG);

  wire free_ge8  = ((5'h10 - count_reg) >= `ECPX_THRESH);
  wire fill_ge8  = (count_reg >= `ECPX_THRESH);
  wire dma_en    = ectl_reg[`ECPX_BIT_DMAEN];
  wire serv_evt  = (dma_en & dma_tc) | (~dma_en & ~dir & free_ge8) | (~dma_en & dir & fill_ge8);
  // fault edge or unmask while asserted
  wire fmask_clr = wr_acc & (paddr == `ECPX_ADDR_ECTL) & ectl_reg[`ECPX_BIT_FMASK] &
                   ~wbyte[`ECPX_BIT_FMASK];
  wire fault_evt = ~ectl_reg[`ECPX_BIT_FMASK] & fault_d_reg & ~fault_n;
  wire fault_unm = fmask_clr & ~fault_n;

  // read mux for all mapped registers
  always @* begin
    rdata_next = 8'h00;
    hit = 1'b1;
    case (paddr)
      `ECPX_ADDR_FIFO: begin
        rdata_next = fifo_mem_reg[rd_ptr_reg];
      end
      `ECPX_ADDR_CFGA: begin
        rdata_next = in_cfg ? (`ECPX_CFGA_FIXED | {4'h0, ppcfg_reg[`ECPX_BIT_CFGA7], 3'h0}) : 8'h00;
      end
      `ECPX_ADDR_CFGB: begin
        rdata_next = in_cfg ? {1'b0, irq_level, ppcfg_reg[5:3], 1'b0, ppcfg_reg[1:0]} : 8'h00;
      end
      `ECPX_ADDR_ECTL: begin
        rdata_next = {ectl_reg[7:3], ectl_reg[`ECPX_BIT_SERV] & ~clk_frozen,
                      fifo_full | clk_frozen, fifo_empty | clk_frozen};
      end
      `ECPX_ADDR_INDEX: begin
        rdata_next = {5'h00, index_reg};
      end
      `ECPX_ADDR_DATA: begin
        if (sl_valid(index_reg, sl_enable)) begin
          case (index_reg)
            `ECPX_SL_CTRL0: rdata_next = ctrl0_reg;
            `ECPX_SL_CTRL2: rdata_next = ctrl2_reg;
            `ECPX_SL_CTRL4: rdata_next = ctrl4_reg;
            default:        rdata_next = ppcfg_reg;
          endcase
        end
      end
      `ECPX_ADDR_PCTL: begin
        rdata_next = pctl_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // apb answer: no wait state, plus a one-cycle stall on control reads until status settles
  always @(posedge clock) begin
    if (!rst_n) begin
      pready_reg     <= 1'b0;
      prdata_reg     <= 32'h00000000;
      pslverr_reg    <= 1'b0;
      stat_valid_reg <= 1'b0;
    end else begin
      // status counts as updated once a cycle has passed with no FIFO change
      stat_valid_reg <= ~(push | pop);
      if (setup | (psel & penable & ~pready_reg)) begin
        if (~pwrite & (paddr == `ECPX_ADDR_ECTL) & ~stat_valid_reg) begin
          pready_reg <= 1'b0;
        end else begin
          pready_reg  <= 1'b1;
          prdata_reg  <= {24'h000000, rdata_next};
          pslverr_reg <= ~hit;
        end
      end else begin
        pready_reg  <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // FIFO storage; order kept regardless of direction
  always @(posedge clock) begin
    if (!rst_n) begin
      rd_ptr_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
      for (i = 0; i < `ECPX_FIFO_DEPTH; i = i + 1) begin
        fifo_mem_reg[i] <= 8'h00;
      end
    end else begin
      if (push) begin
        fifo_mem_reg[wr_ptr_reg] <= wbyte;
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 5'h01;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 5'h01;
      end
    end
  end

  // control registers; second-level ones return to defaults only here on reset
  always @(posedge clock) begin
    if (!rst_n) begin
      ectl_reg    <= `ECPX_ECTL_RESET;
      index_reg   <= 3'h0;
      ctrl0_reg   <= 8'h00;
      ctrl2_reg   <= 8'h00;
      ctrl4_reg   <= `ECPX_CTRL4_RESET;
      ppcfg_reg   <= 8'h00;
      pctl_reg    <= `ECPX_PCTL_RESET;
      fault_d_reg <= 1'b1;
      irq_reg     <= 1'b0;
    end else begin
      fault_d_reg <= fault_n;
      irq_reg     <= 1'b0;
      if (wr_acc & (paddr == `ECPX_ADDR_ECTL)) begin
        ectl_reg[7:3] <= wbyte[7:3];
        ectl_reg[`ECPX_BIT_SERV] <= wbyte[`ECPX_BIT_SERV];
      end
      // event sets service bit only while it is clear, set wins
      if (~ectl_reg[`ECPX_BIT_SERV] & serv_evt) begin
        ectl_reg[`ECPX_BIT_SERV] <= 1'b1;
        irq_reg <= 1'b1;
      end
      if (fault_evt | fault_unm) begin
        irq_reg <= 1'b1;
      end
      if (wr_acc & (paddr == `ECPX_ADDR_INDEX)) begin
        index_reg <= wbyte[2:0];
      end
      if (wr_acc & (paddr == `ECPX_ADDR_DATA) & sl_valid(index_reg, sl_enable)) begin
        case (index_reg)
          `ECPX_SL_CTRL0: ctrl0_reg <= wbyte;
          `ECPX_SL_CTRL2: ctrl2_reg <= wbyte;
          `ECPX_SL_CTRL4: ctrl4_reg <= wbyte;
          default:        ppcfg_reg <= wbyte;
        endcase
      end
      if (wr_acc & (paddr == `ECPX_ADDR_PCTL)) begin
        pctl_reg <= wbyte;
      end
    end
  end

  // pins: data lines, DMA request; the interrupt is registered in the control block
  always @(posedge clock) begin
    if (!rst_n) begin
      pd_out_reg       <= 8'h00;
      pd_oe_n_reg      <= 1'b0;
      dma_req_reg      <= 1'b0;
      dma_req_oe_n_reg <= 1'b1;
    end else begin
      // drive forward, release backward; lines carry the FIFO head byte in every mode
      pd_oe_n_reg <= dir;
      pd_out_reg  <= fifo_mem_reg[rd_ptr_reg];
      // request only while enabled and armed; floated when disabled
      dma_req_oe_n_reg <= ~dma_en;
      dma_req_reg      <= dma_en & ~ectl_reg[`ECPX_BIT_SERV] & ~in_test & ~in_cfg;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign pd_out       = pd_out_reg;
  assign pd_oe_n      = pd_oe_n_reg;
  assign dma_req      = dma_req_reg;
  assign dma_req_oe_n = dma_req_oe_n_reg;
  assign irq_out      = irq_reg;
endmodule

// [tb/ecpx_props.sv]
// ecpx_props.sv: port checker for the extended register set.
// assumes: bound to ecpx_ext_regs; APB master holds each request until pready.
`include "ecpx_defs.vh"
module ecpx_props (
  input logic        clock,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        clk_frozen,
  input logic        sl_enable,
  input logic        pd_oe_n,
  input logic        dma_req,
  input logic        dma_req_oe_n,
  input logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // completed read; address is still held by the master here
  wire rd_done = pready && !pwrite;
  chk_ready_bound: assert property (psel && !penable |-> ##[1:2] pready)
    else $error("pready late");
  chk_cfga_fixed: assert property (rd_done && paddr == `ECPX_ADDR_CFGA && prdata != 0
    |-> prdata[7:4] == 4'h1 && prdata[2:0] == 3'h4) else $error("config a pattern");
  chk_cfgb_zero: assert property (rd_done && paddr == `ECPX_ADDR_CFGB |-> !prdata[7] && !prdata[2])
    else $error("config b zero bits");
  chk_frozen_read: assert property (rd_done && paddr == `ECPX_ADDR_ECTL && clk_frozen && $past(clk_frozen)
    |-> prdata[2:0] == 3'h3) else $error("frozen readback");
  chk_req_driven: assert property (dma_req |-> !dma_req_oe_n)
    else $error("request not driven");
  chk_irq_pulse: assert property (irq_out |=> !irq_out)
    else $error("irq too long");
  chk_sl_gate: assert property (rd_done && paddr == `ECPX_ADDR_DATA && !sl_enable |-> prdata == 0)
    else $error("second level open");
  chk_dir_follow: assert property (pready && pwrite && paddr == `ECPX_ADDR_PCTL
    |=> ##1 pd_oe_n == $past(pwdata[5], 2)) else $error("direction drive");
  chk_index_zero: assert property (rd_done && paddr == `ECPX_ADDR_INDEX |-> prdata[7:3] == 5'h00)
    else $error("index high bits");
  cover property (irq_out);
  cover property (rd_done && paddr == `ECPX_ADDR_ECTL && prdata[1]);
  cover property (rd_done && clk_frozen);
endmodule
bind ecpx_ext_regs ecpx_props u_props (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .clk_frozen(clk_frozen), .sl_enable(sl_enable), .pd_oe_n(pd_oe_n), .dma_req(dma_req),
  .dma_req_oe_n(dma_req_oe_n), .irq_out(irq_out));

// [tb/ecpx_periph.sv]
// ecpx_periph.sv: behavioural peripheral on the cable side.
// assumes: bench commands the fault level; host drive arrives on pd_out/pd_oe_n.
module ecpx_periph (
  input  wire logic       clock,
  input  wire logic       fault_cmd,
  input  wire logic [7:0] pd_out,
  input  wire logic       pd_oe_n,
  output logic            fault_n = 1'h1,
  output logic [7:0]      pd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pat_reg = 8'h5a;
  // fault changes just after an edge; released lines toggle so no stale byte looks valid
  always @(posedge clock) begin
    fault_n <= !fault_cmd;
    pat_reg <= ~pat_reg;
  end
  assign pd_in = pd_oe_n ? pat_reg : pd_out;
endmodule

// [tb/ecpx_ext_regs_tb_top.sv]
// ecpx_ext_regs_tb_top.sv: self-checking bench for the extended register set.
// assumes: design, checker and peripheral model compiled first; one clock.
`include "ecpx_defs.vh"
module ecpx_ext_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        clk_frozen = 1'h0, irq_level = 1'h0, dma_tc = 1'h0, sl_enable = 1'h1, fault_cmd = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, pd_oe_n, dma_req, dma_req_oe_n, irq_out, fault_n, rerr;
  logic [7:0]  pd_in, pd_out;
  int          err_count = 0, checked = 0, irq_cnt = 0;
  ecpx_ext_regs dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_frozen(clk_frozen), .fault_n(fault_n), .irq_level(irq_level), .dma_tc(dma_tc),
    .sl_enable(sl_enable), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .dma_req(dma_req),
    .dma_req_oe_n(dma_req_oe_n), .irq_out(irq_out));
  ecpx_periph u_periph (.clock(clock), .fault_cmd(fault_cmd), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .fault_n(fault_n), .pd_in(pd_in));
  // 100 ns period; interrupt pulses counted so none is missed between bus cycles
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    if (irq_out === 1'h1) irq_cnt++;
  end
  task final_report;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one APB transfer, entered just after an edge; one idle edge after release
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) err_count++;
    if (n >= 20) final_report;
    @(posedge clock);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  task irq_wait(input string nm, input int b);
    int n;
    n = 0;
    while (irq_cnt == b && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk(nm, b + 1, irq_cnt);
    if (n >= 20) final_report;
  endtask
  task t_reset;
    rd("ectl", `ECPX_ADDR_ECTL, 32'h15);
    rd("index", `ECPX_ADDR_INDEX, 32'h0);
    chk("dma oe", 1, dma_req_oe_n);
  endtask
  task t_fifo;
    int i;
    apb(1'h1, `ECPX_ADDR_ECTL, 32'hd4);
    chk("pd oe", 0, pd_oe_n);
    for (i = 0; i < 17; i++) apb(1'h1, `ECPX_ADDR_FIFO, 32'h44 - i);
    rd("full", `ECPX_ADDR_ECTL, 32'hd6);
    for (i = 0; i < 16; i++) rd("pop", `ECPX_ADDR_FIFO, 32'h44 - i);
    apb(1'h0, `ECPX_ADDR_FIFO, 32'h0);
    rd("empty", `ECPX_ADDR_ECTL, 32'hd5);
    apb(1'h1, `ECPX_ADDR_PCTL, 32'h20);
    apb(1'h1, `ECPX_ADDR_FIFO, 32'h11);
    apb(1'h1, `ECPX_ADDR_FIFO, 32'h22);
    chk("pd rel", 1, pd_oe_n);
    rd("rev1", `ECPX_ADDR_FIFO, 32'h11);
    rd("rev2", `ECPX_ADDR_FIFO, 32'h22);
    apb(1'h1, `ECPX_ADDR_PCTL, 32'h0);
  endtask
  task t_service;
    int b;
    b = irq_cnt;
    apb(1'h1, `ECPX_ADDR_ECTL, 32'hd0);
    irq_wait("thresh", b);
    rd("serv", `ECPX_ADDR_ECTL, 32'hd5);
    clk_frozen <= 1'h1;
    rd("frozen", `ECPX_ADDR_ECTL, 32'hd3);
    clk_frozen <= 1'h0;
    b = irq_cnt;
    apb(1'h1, `ECPX_ADDR_ECTL, 32'hd8);
    dma_tc <= 1'h1;
    @(posedge clock);
    dma_tc <= 1'h0;
    chk("dma on", 0, dma_req_oe_n);
    irq_wait("tc", b);
    apb(1'h1, `ECPX_ADDR_ECTL, 32'hd4);
  endtask
  task t_fault;
    int b;
    apb(1'h1, `ECPX_ADDR_ECTL, 32'h04);
    b = irq_cnt;
    fault_cmd <= 1'h1;
    irq_wait("fall", b);
    apb(1'h1, `ECPX_ADDR_ECTL, 32'h14);
    b = irq_cnt;
    apb(1'h1, `ECPX_ADDR_ECTL, 32'h04);
    irq_wait("unmask", b);
    fault_cmd <= 1'h0;
  endtask
  task t_modes;
    int m;
    for (m = 0; m < 8; m++) begin
      if (m != 5) apb(1'h1, `ECPX_ADDR_ECTL, {m[2:0], 5'h14});
      if (m != 5) rd("mode", `ECPX_ADDR_ECTL, {m[2:0], 5'h15});
    end
  endtask
  task t_config;
    apb(1'h1, `ECPX_ADDR_INDEX, 32'hfd);
    rd("idx", `ECPX_ADDR_INDEX, 32'h05);
    apb(1'h1, `ECPX_ADDR_DATA, 32'hbb);
    rd("sl data", `ECPX_ADDR_DATA, 32'hbb);
    apb(1'h1, `ECPX_ADDR_INDEX, 32'h01);
    apb(1'h1, `ECPX_ADDR_DATA, 32'h55);
    rd("sl gap", `ECPX_ADDR_DATA, 32'h0);
    apb(1'h1, `ECPX_ADDR_INDEX, 32'h05);
    sl_enable <= 1'h0;
    rd("sl off", `ECPX_ADDR_DATA, 32'h0);
    sl_enable <= 1'h1;
    irq_level <= 1'h1;
    apb(1'h1, `ECPX_ADDR_CFGA, 32'hff);
    apb(1'h1, `ECPX_ADDR_CFGB, 32'hff);
    rd("cfga", `ECPX_ADDR_CFGA, 32'h1c);
    rd("cfgb", `ECPX_ADDR_CFGB, 32'h7b);
    rd("unmapped", 12'h01c, 32'h0);
    chk("slverr", 1, rerr);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    t_reset;
    t_fifo;
    t_service;
    t_fault;
    t_modes;
    t_config;
    final_report;
  end
endmodule
